// file: src/pmt_map.svh
// Purpose: register map, field positions, reset values and timing counts of the
//          period match timer
// Assumes: 12-bit byte address on the register bus, 32-bit data
// Notes:   byte address of a register is four times its index
`ifndef PMT_MAP_SVH
`define PMT_MAP_SVH

// register indices
`define PMT_IDX_FLAG        8'h0c
`define PMT_IDX_TICK        8'h11
`define PMT_IDX_CTRL        8'h12
`define PMT_IDX_MASK        8'h8c
`define PMT_IDX_PERIOD      8'h92
`define PMT_BYTE_ADDR(idx)  ({2'b00, (idx), 2'b00})

// field positions
`define PMT_CTL_PRE_LSB     0
`define PMT_CTL_PRE_MSB     1
`define PMT_CTL_ON_BIT      2
`define PMT_CTL_POST_LSB    3
`define PMT_CTL_POST_MSB    6
`define PMT_FLAG_MATCH_BIT  1

// reset values
`define PMT_TICK_RST        8'h00
`define PMT_PERIOD_RST      8'hff
`define PMT_CTRL_RST        7'h00
`define PMT_FLAG_RST        1'b0
`define PMT_MASK_RST        1'b0

// timing counts: last phase of the oscillator-by-four divider and prescaler ends
`define PMT_PHASE_LAST      2'h3
`define PMT_PRE4_LAST       4'h3
`define PMT_PRE16_LAST      4'hf

`endif

// file: src/pmt_pkg.sv
// Purpose: shared types of the period match timer
// Assumes: apb3 style slave, no byte strobes
// Notes:   control struct layout equals the control register bits 6:0
package pmt_pkg;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } pmt_apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } pmt_apb_rsp_s;

    typedef enum logic [1:0] {
        PMT_PRE_DIV1   = 2'b00,
        PMT_PRE_DIV4   = 2'b01,
        PMT_PRE_DIV16  = 2'b10,
        PMT_PRE_DIV16B = 2'b11
    } pmt_pre_e;

    typedef struct packed {
        logic [3:0] post_divide_select;
        logic       count_on;
        pmt_pre_e   pre_divide_select;
    } pmt_ctrl_s;

    typedef enum logic [1:0] {
        PMT_BUS_IDLE   = 2'b00,
        PMT_BUS_ANSWER = 2'b01
    } pmt_bus_e;

endpackage

// file: src/pmt_prescaler.sv
// Purpose: input prescaler of the period match timer
// Assumes: inst_tick is a one-cycle pulse at the instruction rate
// Notes:   output tick is combinational, one cycle wide
`timescale 1ns/1ns
`include "pmt_map.svh"
module pmt_prescaler (
    input  logic              pclk,
    input  logic              presetn,
    input  logic              clk_en,
    input  logic              inst_tick,
    input  logic              clear,
    input  logic              run,
    input  pmt_pkg::pmt_pre_e sel,
    output logic              tick
);
    import pmt_pkg::*;

    typedef struct packed {
        logic [3:0] count;
    } pmt_pre_state_s;

    pmt_pre_state_s state_reg;
    pmt_pre_state_s state_next;
    logic           hit;

    // divider end and next count; clear beats any tick in the same cycle
    always_comb begin
        state_next = state_reg;
        hit        = 1'b0;
        case (sel)
            PMT_PRE_DIV1: begin
                hit = 1'b1;
            end
            PMT_PRE_DIV4: begin
                hit = (state_reg.count == `PMT_PRE4_LAST);
            end
            default: begin
                hit = (state_reg.count == `PMT_PRE16_LAST);
            end
        endcase
        tick = run & inst_tick & hit & ~clear; // RL3
        if (clear) begin
            state_next.count = 4'h0; // RL7
        end else if (run & inst_tick) begin
            state_next.count = hit ? 4'h0 : state_reg.count + 4'h1; // RL3
        end
    end

    // state register, frozen while clk_en is low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= '0; // RL7
        end else if (clk_en) begin
            state_reg <= state_next;
        end
    end

endmodule

// file: src/pmt_postscaler.sv
// Purpose: match postscaler of the period match timer
// Assumes: match is a one-cycle pulse
// Notes:   field value n gives one fire per n+1 matches
`timescale 1ns/1ns
module pmt_postscaler (
    input  logic       pclk,
    input  logic       presetn,
    input  logic       clk_en,
    input  logic       match,
    input  logic       clear,
    input  logic [3:0] sel,
    output logic       fire
);
    typedef struct packed {
        logic [3:0] count;
    } pmt_post_state_s;

    pmt_post_state_s state_reg;
    pmt_post_state_s state_next;

    // match counting; a clear drops a match of the same cycle
    always_comb begin
        state_next = state_reg;
        fire       = match & ~clear & (state_reg.count == sel); // RL4
        if (clear) begin
            state_next.count = 4'h0; // RL7
        end else if (match) begin
            state_next.count = fire ? 4'h0 : state_reg.count + 4'h1; // RL4
        end
    end

    // state register, frozen while clk_en is low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= '0; // RL7
        end else if (clk_en) begin
            state_reg <= state_next;
        end
    end

endmodule

// file: src/pmt_timer.sv
// Purpose: 8-bit period match timer with prescaler, postscaler and apb registers
// Assumes: pclk is the oscillator clock; the counter runs from pclk divided by four
// Notes:   one wait state on every apb access; match pulse feeds the pwm unit
//
// Functional notes
// (RL1) 8-bit counter, software read and write
// (RL2) 8-bit period limit, compared each increment
// (RL3) prescale oscillator/4 by 1, 4 or 16
// (RL4) postscaler flags once per n+1 matches
// (RL5) postscaler completion sets sticky match flag
// (RL6) control bit 2 runs or stops counter
// (RL7) counter/control writes and reset clear dividers
// (RL8) control write keeps counter value
// (RL9) reset clears counter to zero
// (RL10) match event drives pwm time base
// (RL11) count to period, then wrap to zero
// (RL12) period limit resets to all ones
// (RL13) counter write beats same-cycle increment
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ns
`include "pmt_map.svh"
module pmt_timer (
    input  logic                  pclk,
    input  logic                  presetn,
    input  logic                  clk_en,
    input  pmt_pkg::pmt_apb_req_s apb_req,
    output pmt_pkg::pmt_apb_rsp_s apb_rsp,
    output logic                  irq,
    output logic                  time_base_pulse,
    output logic [7:0]            tick_value
);
    import pmt_pkg::*;

    // whole state of the top level in one record
    typedef struct packed {
        pmt_bus_e     bus;
        logic [1:0]   phase;
        logic [7:0]   tick_count;
        logic [7:0]   period_limit;
        pmt_ctrl_s    ctrl;
        logic         match_flag;
        logic         match_mask;
        logic         time_base;
        logic         irq;
        pmt_apb_rsp_s rsp;
    } pmt_top_state_s;

    pmt_top_state_s state_reg;
    pmt_top_state_s state_next;

    // decoded bus terms
    logic        access;
    logic        commit;
    logic        wr_commit;
    logic        hit_tick;
    logic        hit_period;
    logic        hit_ctrl;
    logic        hit_flag;
    logic        hit_mask;
    logic        addr_hit;
    logic        wr_tick;
    logic        wr_period;
    logic        wr_ctrl;
    logic        wr_flag;
    logic        wr_mask;
    logic [31:0] read_word;
    logic [7:0]  wdata;

    // timer datapath terms
    logic        inst_tick;
    logic        div_clear;
    logic        pre_tick;
    logic        at_limit;
    logic        period_match;
    logic        post_fire;

    // outputs come straight from the state register
    assign apb_rsp         = state_reg.rsp;
    assign irq             = state_reg.irq;
    assign time_base_pulse = state_reg.time_base; // RL10
    assign tick_value      = state_reg.tick_count; // RL10

    // address decode; byte address is four times the register index
    always_comb begin
        hit_tick   = 1'b0;
        hit_period = 1'b0;
        hit_ctrl   = 1'b0;
        hit_flag   = 1'b0;
        hit_mask   = 1'b0;
        case (apb_req.paddr)
            `PMT_BYTE_ADDR(`PMT_IDX_TICK): begin
                hit_tick = 1'b1;
            end
            `PMT_BYTE_ADDR(`PMT_IDX_PERIOD): begin
                hit_period = 1'b1;
            end
            `PMT_BYTE_ADDR(`PMT_IDX_CTRL): begin
                hit_ctrl = 1'b1;
            end
            `PMT_BYTE_ADDR(`PMT_IDX_FLAG): begin
                hit_flag = 1'b1;
            end
            `PMT_BYTE_ADDR(`PMT_IDX_MASK): begin
                hit_mask = 1'b1;
            end
            default: begin
                hit_tick = 1'b0;
            end
        endcase
        addr_hit = hit_tick | hit_period | hit_ctrl | hit_flag | hit_mask;
    end

    // read mux; narrow registers sit in the low bits, the rest reads zero
    always_comb begin
        read_word = 32'h0000_0000;
        if (hit_tick) begin
            read_word[7:0] = state_reg.tick_count; // RL1
        end
        if (hit_period) begin
            read_word[7:0] = state_reg.period_limit; // RL2
        end
        if (hit_ctrl) begin
            read_word[`PMT_CTL_POST_MSB:`PMT_CTL_PRE_LSB] = state_reg.ctrl;
        end
        if (hit_flag) begin
            read_word[`PMT_FLAG_MATCH_BIT] = state_reg.match_flag; // RL5
        end
        if (hit_mask) begin
            read_word[`PMT_FLAG_MATCH_BIT] = state_reg.match_mask;
        end
    end

    // a write lands only at the edge where pready is seen high
    assign access    = apb_req.psel & apb_req.penable;
    assign commit    = access & (state_reg.bus == PMT_BUS_ANSWER);
    assign wr_commit = commit & apb_req.pwrite;
    assign wr_tick   = wr_commit & hit_tick;
    assign wr_period = wr_commit & hit_period;
    assign wr_ctrl   = wr_commit & hit_ctrl;
    assign wr_flag   = wr_commit & hit_flag;
    assign wr_mask   = wr_commit & hit_mask;
    assign wdata     = apb_req.pwdata[7:0];

    // both dividers restart on a counter or control write
    assign div_clear = wr_tick | wr_ctrl; // RL7

    // instruction rate: one pulse every fourth oscillator cycle
    assign inst_tick = (state_reg.phase == `PMT_PHASE_LAST); // RL3

    // limit compare; the wrap increment itself is the match event
    assign at_limit     = (state_reg.tick_count == state_reg.period_limit); // RL2
    assign period_match = pre_tick & at_limit & ~wr_tick; // RL11

    // prescaler only advances while the timer is switched on
    pmt_prescaler pmt_prescaler_inst (
        .pclk      (pclk),
        .presetn   (presetn),
        .clk_en    (clk_en),
        .inst_tick (inst_tick),
        .clear     (div_clear),
        .run       (state_reg.ctrl.count_on), // RL6
        .sel       (state_reg.ctrl.pre_divide_select),
        .tick      (pre_tick)
    );

    // postscaler counts period matches into flag events
    pmt_postscaler pmt_postscaler_inst (
        .pclk    (pclk),
        .presetn (presetn),
        .clk_en  (clk_en),
        .match   (period_match),
        .clear   (div_clear),
        .sel     (state_reg.ctrl.post_divide_select),
        .fire    (post_fire)
    );

    // next state of counter, registers, flag and bus answer
    always_comb begin
        state_next = state_reg;

        // free running quarter-rate phase; it is clocking, not timer state
        state_next.phase = state_reg.phase + 2'h1;

        // counter: software write wins, else step on each prescaled tick
        if (wr_tick) begin
            state_next.tick_count = wdata; // RL13
        end else if (pre_tick) begin
            if (at_limit) begin
                state_next.tick_count = 8'h00; // RL11
            end else begin
                state_next.tick_count = state_reg.tick_count + 8'h01; // RL11
            end
        end

        // period limit holds any value; a limit below the count lets it run to ff
        if (wr_period) begin
            state_next.period_limit = wdata; // RL2
        end

        // control write changes control and restarts both dividers; the count is kept as it is
        if (wr_ctrl) begin
            state_next.ctrl = pmt_ctrl_s'(wdata[`PMT_CTL_POST_MSB:`PMT_CTL_PRE_LSB]); // RL8
        end

        // mask gates the flag onto the interrupt line
        if (wr_mask) begin
            state_next.match_mask = wdata[`PMT_FLAG_MATCH_BIT];
        end

        // write one to clear; a new event in the same cycle keeps it set
        if (wr_flag & wdata[`PMT_FLAG_MATCH_BIT]) begin
            state_next.match_flag = 1'b0;
        end
        if (post_fire) begin
            state_next.match_flag = 1'b1; // RL5
        end

        // level interrupt follows the flag and mask of the same cycle
        state_next.irq = state_next.match_flag & state_next.match_mask;

        // one-cycle pwm time base pulse per period
        state_next.time_base = period_match; // RL10

        // bus: answer one cycle into the access phase, then drop pready
        case (state_reg.bus)
            PMT_BUS_IDLE: begin
                state_next.rsp.pready  = 1'b0;
                state_next.rsp.pslverr = 1'b0;
                if (access) begin
                    state_next.bus         = PMT_BUS_ANSWER;
                    state_next.rsp.pready  = 1'b1;
                    state_next.rsp.pslverr = ~addr_hit;
                    if (!apb_req.pwrite) begin
                        state_next.rsp.prdata = read_word; // RL1
                    end
                end
            end
            PMT_BUS_ANSWER: begin
                state_next.bus         = PMT_BUS_IDLE;
                state_next.rsp.pready  = 1'b0;
                state_next.rsp.pslverr = 1'b0;
            end
            default: begin
                state_next.bus         = PMT_BUS_IDLE;
                state_next.rsp.pready  = 1'b0;
                state_next.rsp.pslverr = 1'b0;
            end
        endcase
    end

    // state register; clk_en low freezes the whole timer and the bus answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg.bus          <= PMT_BUS_IDLE;
            state_reg.phase        <= 2'h0;
            state_reg.tick_count   <= `PMT_TICK_RST; // RL9
            state_reg.period_limit <= `PMT_PERIOD_RST; // RL12
            state_reg.ctrl         <= pmt_ctrl_s'(`PMT_CTRL_RST); // RL6
            state_reg.match_flag   <= `PMT_FLAG_RST;
            state_reg.match_mask   <= `PMT_MASK_RST;
            state_reg.time_base    <= 1'b0;
            state_reg.irq          <= 1'b0;
            state_reg.rsp          <= '0;
        end else if (clk_en) begin
            state_reg <= state_next;
        end
    end

    // count_on gates the prescaler run input above, so the counter sits still
    // while off; the quarter-rate phase keeps turning, which costs two bits only
    // and keeps the first tick after switch-on within four cycles
    // RL6 is carried by the run connection of the prescaler instance

endmodule

// file: test/pmt_timer_props.sv
// Purpose: port checks of the period match timer
// Assumes: clk_en dropped by the bench only while the bus is idle
// Notes:   bound from the bench top file
`timescale 1ns/1ns
module pmt_timer_props (
    input wire logic                  pclk,
    input wire logic                  presetn,
    input wire logic                  clk_en,
    input wire pmt_pkg::pmt_apb_req_s apb_req,
    input wire pmt_pkg::pmt_apb_rsp_s apb_rsp,
    input wire logic                  irq,
    input wire logic                  time_base_pulse,
    input wire logic [7:0]            tick_value
);
    import pmt_pkg::*;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic wr_go;
    logic tick_wr;
    // a write lands at the edge where the access sees pready
    assign wr_go   = apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite;
    assign tick_wr = wr_go && apb_req.paddr == 12'h044;

    ans_one_wait_a: assert property (
        clk_en && apb_req.psel && apb_req.penable && !apb_rsp.pready |=> apb_rsp.pready)
        else $error("pready not one cycle after access");
    ready_pulse_a: assert property (clk_en && apb_rsp.pready |=> !apb_rsp.pready)
        else $error("pready held too long");
    err_unmapped_a: assert property (
        apb_rsp.pslverr |-> !(apb_req.paddr inside {12'h030, 12'h044, 12'h048, 12'h230, 12'h248}))
        else $error("error on a mapped address");
    tick_zero_rst_a: assert property ($rose(presetn) |-> tick_value == 8'h00)
        else $error("counter not zero after reset");
    tick_step_a: assert property (
        $changed(tick_value) && !$past(tick_wr)
        |-> tick_value == $past(tick_value) + 8'h01 || tick_value == 8'h00)
        else $error("counter moved other than by one");
    wrap_pulse_a: assert property (time_base_pulse |-> tick_value == 8'h00)
        else $error("match pulse without wrap");
    zero_has_pulse_a: assert property (
        $changed(tick_value) && tick_value == 8'h00 && !$past(tick_wr) |-> time_base_pulse)
        else $error("wrap without match pulse");
    tick_gap_a: assert property (
        $changed(tick_value) && !$past(tick_wr) |=> ($stable(tick_value) || $past(tick_wr))[*3])
        else $error("counter faster than instruction rate");
    irq_fall_a: assert property ($fell(irq) |-> $past(wr_go))
        else $error("irq dropped without a write");
    irq_rise_a: assert property ($rose(irq) |-> time_base_pulse || $past(wr_go))
        else $error("irq raised without match");

    // main scenarios reached
    cover property (time_base_pulse);
    cover property ($rose(irq));
    cover property (apb_rsp.pslverr);
endmodule

// file: test/pmt_timer_test.sv
// Purpose: self-checking bench of the period match timer
// Assumes: clk_en dropped only while the bus is idle; the apb master waits for pready
// Notes:   seeded xorshift stimulus with fixed corner cases
`timescale 1ns/1ns
module pmt_timer_test;
    import pmt_pkg::*;
    logic         pclk        = 1'b0;
    logic         presetn     = 1'b0;
    logic         clk_en      = 1'b1;
    pmt_apb_req_s apb_req     = '0;
    pmt_apb_rsp_s apb_rsp;
    logic         irq;
    logic         time_base_pulse;
    logic [7:0]   tick_value;
    int           err_count   = 0;
    int           checks_done = 0;
    int           cycles      = 0;
    logic [31:0]  seed        = 32'd38;
    logic [31:0]  rd;
    logic         serr;
    logic [7:0]   v;
    int           n, p, k, c, t, t1;

    pmt_timer pmt_timer_inst (
        .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .apb_req(apb_req),
        .apb_rsp(apb_rsp), .irq(irq), .time_base_pulse(time_base_pulse),
        .tick_value(tick_value));

    // 25 mhz clock
    initial begin
        forever #20 pclk = ~pclk;
    end

    // hang guard, far above the longest run
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            err_count++;
            summarize();
        end
    end

    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // one apb transfer; the request stands until pready is sampled
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int w8;
        w8 = 0;
        @(posedge pclk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge pclk);
            w8++;
        end while (apb_rsp.pready !== 1'b1 && w8 < 20);
        rd   = apb_rsp.prdata;
        serr = apb_rsp.pslverr;
        apb_req.psel    <= 1'b0;
        apb_req.penable <= 1'b0;
        if (w8 >= 20) err_count++;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdx(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    // cycles between two later counter changes
    task automatic gap(output int g);
        logic [7:0] o;
        for (int i = 0; i < 2; i++) begin
            o = tick_value;
            g = 0;
            while (tick_value === o && g < 200) begin
                @(posedge pclk);
                g++;
            end
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdx(12'h044, 32'h0);
        rdx(12'h248, 32'hff);
        rdx(12'h048, 32'h0);
        rdx(12'h030, 32'h0);
        rdx(12'h230, 32'h0);
        rdx(12'h100, 32'h0);
        chk(serr, 1'b1);
        for (k = 0; k < 8; k++) begin
            seed = xs(seed);
            wr(12'h248, seed);
            rdx(12'h248, {24'h0, seed[7:0]});
            wr(12'h044, seed >> 8);
            rdx(12'h044, {24'h0, seed[15:8]});
        end
        wr(12'h048, 32'hff);
        rdx(12'h048, 32'h7f);
        $display("register access done");
        // a stopped timer holds; a control write keeps the count
        wr(12'h048, 32'h0);
        wr(12'h044, 32'h5a);
        wr(12'h048, 32'h79);
        repeat (100) @(posedge pclk);
        chk(tick_value, 8'h5a);
        rdx(12'h044, 32'h5a);
        wr(12'h248, 32'hff);
        for (k = 0; k < 4; k++) begin
            wr(12'h044, 32'h0);
            wr(12'h048, 32'h4 | k);
            gap(n);
            chk(n, (k == 0) ? 4 : (k == 1) ? 16 : 64);
        end
        // counter write loads at once and restarts the prescaler
        v = seed[7:0] & 8'h7f;
        wr(12'h044, {24'h0, v});
        @(posedge pclk);
        chk(tick_value, v);
        n = 0;
        while (tick_value === v && n < 200) begin
            @(posedge pclk);
            n++;
        end
        chk(n >= 58 && n <= 67, 1'b1);
        chk(tick_value, v + 8'h01);
        // clock enable low freezes a running counter
        @(posedge pclk);
        clk_en <= 1'b0;
        @(posedge pclk);
        v = tick_value;
        repeat (100) @(posedge pclk);
        chk(tick_value, v);
        clk_en <= 1'b1;
        $display("prescaler done");
        // period and postscaler sweep, corners first
        for (k = 0; k < 6; k++) begin
            seed = xs(seed);
            p = (k == 0) ? 0 : seed[2:0];
            n = (k == 0) ? 15 : (k == 1) ? 0 : seed[6:3];
            wr(12'h048, 32'h0);
            wr(12'h248, p);
            wr(12'h044, 32'h0);
            wr(12'h030, 32'h2);
            wr(12'h230, 32'h2);
            wr(12'h048, {n[3:0], 3'b100});
            c = 0;
            t = 0;
            t1 = 0;
            while (irq !== 1'b1 && t < 2000) begin
                @(posedge pclk);
                t++;
                if (time_base_pulse === 1'b1) begin
                    c++;
                    if (c == 1) t1 = t;
                    if (c == 2) chk(t - t1, 4 * (p + 1));
                end
            end
            chk(c, n + 1);
            wr(12'h048, 32'h0);
            rdx(12'h030, 32'h2);
            wr(12'h230, 32'h0);
            repeat (2) @(posedge pclk);
            chk(irq, 1'b0);
            wr(12'h230, 32'h2);
            repeat (2) @(posedge pclk);
            chk(irq, 1'b1);
            wr(12'h030, 32'h2);
            repeat (2) @(posedge pclk);
            chk(irq, 1'b0);
        end
        $display("postscaler done");
        summarize();
    end
endmodule

bind pmt_timer pmt_timer_props pmt_timer_props_inst (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .irq(irq), .time_base_pulse(time_base_pulse),
    .tick_value(tick_value));
